// ### logic/msbs_pkg.sv
// constants, register map and types of the motor stop and brake sequencer
package msbs_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_TIME_MS = 10;
	localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DCDB_SCALE = 10;

	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_FREQ   = 8'h04;
	localparam logic [7:0] A_RAMP   = 8'h08;
	localparam logic [7:0] A_CURR   = 8'h0C;
	localparam logic [7:0] A_DCT    = 8'h10;
	localparam logic [7:0] A_SCT    = 8'h14;
	localparam logic [7:0] A_GUARD  = 8'h18;
	localparam logic [7:0] A_UVL    = 8'h1C;
	localparam logic [7:0] A_PREX   = 8'h20;
	localparam logic [7:0] A_STATUS = 8'h24;

	localparam int LO_LSB = 0;
	localparam int HI_LSB = 16;
	localparam int B1_LSB = 8;
	localparam int CTRL_STOP_LSB = 4;
	localparam int CTRL_DI_DC = 8;
	localparam int CTRL_DI_SC = 9;
	localparam int CTRL_AIN = 10;
	localparam int CTRL_HV = 11;
	localparam int ST_UV = 4;

	localparam logic [2:0] MODE_VF = 3'h0;
	localparam logic [2:0] MODE_SLV = 3'h2;
	localparam logic [2:0] MODE_PM = 3'h5;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	localparam logic [15:0] DC_STOP_MAX = 16'h03E8;
	localparam logic [15:0] DC_START_MAX = 16'h2710;
	localparam logic [15:0] SC_T_MAX = 16'h2710;
	localparam logic [15:0] BB_MIN = 16'h000A;
	localparam logic [15:0] BB_MAX = 16'h01F4;
	localparam logic [15:0] UV_T_MAX = 16'h0064;
	localparam logic [15:0] PREEX_T_MAX = 16'h03E8;
	localparam logic [15:0] DC_CUR_MAX = 16'h0064;
	localparam logic [15:0] SC_CUR_MAX = 16'h07D0;
	localparam logic [15:0] PREEX_LVL_MIN = 16'h0032;
	localparam logic [15:0] PREEX_LVL_MAX = 16'h00C8;
	localparam logic [15:0] UV_LO_MIN = 16'h0096;
	localparam logic [15:0] UV_LO_MAX = 16'h012C;
	localparam logic [15:0] UV_HI_MIN = 16'h012C;
	localparam logic [15:0] UV_HI_MAX = 16'h0258;

	typedef enum logic [1:0] {
		STOP_RAMP  = 2'h0,
		STOP_COAST = 2'h1,
		STOP_DCB   = 2'h2,
		STOP_TIMER = 2'h3
	} msbs_stop_t;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_PREEX  = 4'h1,
		S_SSTART = 4'h2,
		S_DSTART = 4'h3,
		S_RUN    = 4'h4,
		S_DECEL  = 4'h5,
		S_SSTOP  = 4'h6,
		S_DSTOP  = 4'h7,
		S_BLOCK  = 4'h8,
		S_BBDC   = 4'h9,
		S_CTMR   = 4'hA
	} msbs_state_t;

	typedef struct packed {
		logic [2:0]  mode;
		msbs_stop_t  stop;
		logic        di_dc_en;
		logic        di_sc_en;
		logic        ain_en;
		logic        hv;
		logic [15:0] brake_freq;
		logic [15:0] min_freq;
		logic [15:0] max_freq;
		logic [15:0] decel_t;
		logic [7:0]  dc_cur;
		logic [7:0]  motor_pct;
		logic [11:0] sc_cur;
		logic [15:0] dc_stop_t;
		logic [15:0] dc_start_t;
		logic [15:0] sc_start_t;
		logic [15:0] sc_stop_t;
		logic [15:0] bb_t;
		logic [15:0] uv_t;
		logic [9:0]  uv_level;
		logic [15:0] preex_t;
		logic [7:0]  preex_lvl;
	} msbs_cfg_t;

	typedef struct packed {
		msbs_state_t fsm;
		logic [15:0] timer;
	} msbs_step_t;

	typedef struct packed {
		msbs_cfg_t   cfg;
		msbs_state_t fsm;
		msbs_stop_t  after;
		logic [15:0] timer;
		logic [18:0] div;
		logic        tick;
		logic [15:0] uv_cnt;
		logic [15:0] f_stop;
		logic        need_rel;
		logic        ss_pend;
		logic        uv;
		logic        run1, run2, dc1, dc2, sc1, sc2;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] hrdata;
		logic        hready;
		logic        hresp;
		logic        blk, dc_req, sc_req, preex_req, decel_req, ss_req, start_min;
		logic [7:0]  brk_cur;
	} msbs_st_t;

	localparam msbs_cfg_t CFG_RST = '{mode: MODE_VF, stop: STOP_RAMP, di_dc_en: 1'b0,
		di_sc_en: 1'b0, ain_en: 1'b0, hv: 1'b0, brake_freq: 16'h0096, min_freq: 16'h0096,
		max_freq: 16'h1770, decel_t: 16'h03E8, dc_cur: 8'h32, motor_pct: 8'h64,
		sc_cur: 12'h3E8, dc_stop_t: 16'h0032, dc_start_t: 16'h0000, sc_start_t: 16'h0000,
		sc_stop_t: 16'h0000, bb_t: 16'h0032, uv_t: 16'h0000, uv_level: 10'h0BE,
		preex_t: 16'h0000, preex_lvl: 8'h64};
endpackage

// ### logic/msbs_top.sv
// stop, brake, undervoltage and pre-excitation sequencer with an ahb-lite register slave
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module msbs_top #(
	parameter int TICK_CYCLES = msbs_pkg::TICK_CYCLES
) (
	input  wire logic        hclk,            // 40 MHz system clock
	input  wire logic        hresetn,         // async reset, active low
	input  wire logic        hsel,            // ahb slave select
	input  wire logic [31:0] haddr,           // ahb address
	input  wire logic [1:0]  htrans,          // ahb transfer type
	input  wire logic        hwrite,          // ahb write
	input  wire logic [2:0]  hsize,           // ahb size, word only
	input  wire logic [31:0] hwdata,          // ahb write data
	input  wire logic        hready,          // ahb bus ready
	output logic      [31:0] hrdata,          // ahb read data
	output logic             hreadyout,       // ahb slave ready
	output logic             hresp,           // ahb response, always okay
	input  wire logic        run_pin,         // run command terminal
	input  wire logic        dc_brake_pin,    // digital input set to dc braking
	input  wire logic        sc_brake_pin,    // digital input set to short-circuit braking
	input  wire logic [15:0] out_freq,        // output frequency, 0.01 Hz
	input  wire logic [9:0]  bus_volts,       // dc bus level, volts
	input  wire logic [7:0]  ain_level,       // analog braking current, percent
	output logic             output_block,    // power stage outputs off
	output logic             dc_brake_req,    // dc injection request
	output logic             sc_brake_req,    // short-circuit braking request
	output logic      [7:0]  brake_current,   // dc current, percent of inverter rating
	output logic      [11:0] sc_current,      // short-circuit limit, 0.1 percent of motor
	output logic             preexcite_req,   // pre-excitation request
	output logic      [7:0]  preexcite_level, // pre-excitation level, percent
	output logic             decel_req,       // ramp down request
	output logic             speed_search_req,// one-cycle speed search start
	output logic             start_at_min,    // run begins at minimum frequency
	output logic             undervoltage_fault // sticky undervoltage flag
);
	msbs_pkg::msbs_st_t   st, next_st;
	msbs_pkg::msbs_step_t step;
	msbs_pkg::msbs_stop_t mode_eff;
	logic                 pm, sensorless_vector_mode, uv_low, uv_trip, thr_hit, addr_ph, di_dc, di_sc;
	logic [7:0]           cur_base;

	function automatic logic [15:0] clamp16(input logic [15:0] v, lo, hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// duration = t * k * f / fmax, saturated to the timer width
	function automatic logic [15:0] scale(input logic [15:0] t, input logic [31:0] k,
			input logic [15:0] f, input logic [15:0] fmax);
		logic [31:0] q;
		q = (fmax == 16'h0000) ? 32'h0000_0000 : (32'(t) * k * 32'(f)) / 32'(fmax);
		return (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
	endfunction

	// optional short-circuit phase, optional dc phase, then the end state
	function automatic msbs_pkg::msbs_step_t brake_seq(input logic use_sc,
			input logic [15:0] sc_t, input logic [15:0] dc_t,
			input msbs_pkg::msbs_state_t s_sc, input msbs_pkg::msbs_state_t s_dc,
			input msbs_pkg::msbs_state_t s_end);
		msbs_pkg::msbs_step_t r;
		if (use_sc && sc_t != 16'h0000) begin
			r = '{fsm: s_sc, timer: sc_t};
		end else if (dc_t != 16'h0000) begin
			r = '{fsm: s_dc, timer: dc_t};
		end else begin
			r = '{fsm: s_end, timer: 16'h0000};
		end
		return r;
	endfunction

	function automatic logic [31:0] rd_mux(input msbs_pkg::msbs_st_t s, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			msbs_pkg::A_CTRL: d = {20'h0_0000, s.cfg.hv, s.cfg.ain_en, s.cfg.di_sc_en,
				s.cfg.di_dc_en, 2'h0, s.cfg.stop, 1'h0, s.cfg.mode};
			msbs_pkg::A_FREQ: d = {s.cfg.min_freq, s.cfg.brake_freq};
			msbs_pkg::A_RAMP: d = {s.cfg.decel_t, s.cfg.max_freq};
			msbs_pkg::A_CURR: d = {4'h0, s.cfg.sc_cur, s.cfg.motor_pct, s.cfg.dc_cur};
			msbs_pkg::A_DCT: d = {s.cfg.dc_start_t, s.cfg.dc_stop_t};
			msbs_pkg::A_SCT: d = {s.cfg.sc_stop_t, s.cfg.sc_start_t};
			msbs_pkg::A_GUARD: d = {s.cfg.uv_t, s.cfg.bb_t};
			msbs_pkg::A_UVL: d = {22'h00_0000, s.cfg.uv_level};
			msbs_pkg::A_PREX: d = {8'h00, s.cfg.preex_lvl, s.cfg.preex_t};
			msbs_pkg::A_STATUS: d = {s.timer, 8'h00, s.ss_pend, s.run2, s.blk, s.uv, s.fsm};
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	always_comb begin
		next_st = st;
		pm = st.cfg.mode == msbs_pkg::MODE_PM;
		sensorless_vector_mode = st.cfg.mode == msbs_pkg::MODE_SLV;
		mode_eff = pm ? msbs_pkg::STOP_RAMP : st.cfg.stop;
		uv_low = bus_volts < st.cfg.uv_level;
		uv_trip = uv_low && (st.cfg.uv_t == 16'h0000 || st.uv_cnt >= st.cfg.uv_t);
		// below the minimum frequency the brake point moves up to it
		thr_hit = (st.cfg.brake_freq < st.cfg.min_freq) ? (out_freq <= st.cfg.min_freq)
			: (out_freq < st.cfg.brake_freq);
		addr_ph = hsel && hready && htrans[1];
		step = '{fsm: msbs_pkg::S_IDLE, timer: 16'h0000};

		// 0.01 s tick
		next_st.tick = 1'b0;
		next_st.div = st.div + 19'h0_0001;
		if (st.div == 19'(TICK_CYCLES - 1)) begin
			next_st.div = 19'h0_0000;
			next_st.tick = 1'b1;
		end
		next_st.run1 = run_pin;
		next_st.run2 = st.run1;
		next_st.dc1 = dc_brake_pin;
		next_st.dc2 = st.dc1;
		next_st.sc1 = sc_brake_pin;
		next_st.sc2 = st.sc1;
		if (st.tick && st.timer != 16'h0000) begin
			next_st.timer = st.timer - 16'h0001;
		end
		if (!uv_low) begin
			next_st.uv_cnt = 16'h0000;
		end else if (st.tick && st.uv_cnt != 16'hFFFF) begin
			next_st.uv_cnt = st.uv_cnt + 16'h0001;
		end

		// register writes land in the data phase; out-of-range values are clamped
		if (st.wr_pend) begin
			unique case (st.wr_addr)
				msbs_pkg::A_CTRL: begin
					next_st.cfg.mode = hwdata[2:0];
					next_st.cfg.stop = msbs_pkg::msbs_stop_t'(hwdata[msbs_pkg::CTRL_STOP_LSB +: 2]);
					next_st.cfg.di_dc_en = hwdata[msbs_pkg::CTRL_DI_DC];
					next_st.cfg.di_sc_en = hwdata[msbs_pkg::CTRL_DI_SC];
					next_st.cfg.ain_en = hwdata[msbs_pkg::CTRL_AIN];
					next_st.cfg.hv = hwdata[msbs_pkg::CTRL_HV];
				end
				msbs_pkg::A_FREQ: begin
					next_st.cfg.brake_freq = hwdata[msbs_pkg::LO_LSB +: 16];
					next_st.cfg.min_freq = hwdata[msbs_pkg::HI_LSB +: 16];
				end
				msbs_pkg::A_RAMP: begin
					next_st.cfg.max_freq = hwdata[msbs_pkg::LO_LSB +: 16];
					next_st.cfg.decel_t = hwdata[msbs_pkg::HI_LSB +: 16];
				end
				msbs_pkg::A_CURR: begin
					next_st.cfg.dc_cur = 8'(clamp16(16'(hwdata[msbs_pkg::LO_LSB +: 8]),
						16'h0000, msbs_pkg::DC_CUR_MAX));
					next_st.cfg.motor_pct = hwdata[msbs_pkg::B1_LSB +: 8];
					next_st.cfg.sc_cur = 12'(clamp16(16'(hwdata[msbs_pkg::HI_LSB +: 12]),
						16'h0000, msbs_pkg::SC_CUR_MAX));
				end
				msbs_pkg::A_DCT: begin
					next_st.cfg.dc_stop_t = clamp16(hwdata[msbs_pkg::LO_LSB +: 16], 16'h0000,
						msbs_pkg::DC_STOP_MAX);
					next_st.cfg.dc_start_t = clamp16(hwdata[msbs_pkg::HI_LSB +: 16], 16'h0000,
						msbs_pkg::DC_START_MAX);
				end
				msbs_pkg::A_SCT: begin
					next_st.cfg.sc_start_t = clamp16(hwdata[msbs_pkg::LO_LSB +: 16], 16'h0000,
						msbs_pkg::SC_T_MAX);
					next_st.cfg.sc_stop_t = clamp16(hwdata[msbs_pkg::HI_LSB +: 16], 16'h0000,
						msbs_pkg::SC_T_MAX);
				end
				msbs_pkg::A_GUARD: begin
					next_st.cfg.bb_t = clamp16(hwdata[msbs_pkg::LO_LSB +: 16], msbs_pkg::BB_MIN,
						msbs_pkg::BB_MAX);
					next_st.cfg.uv_t = clamp16(hwdata[msbs_pkg::HI_LSB +: 16], 16'h0000,
						msbs_pkg::UV_T_MAX);
				end
				msbs_pkg::A_UVL: begin
					next_st.cfg.uv_level = 10'(st.cfg.hv
						? clamp16(16'(hwdata[9:0]), msbs_pkg::UV_HI_MIN, msbs_pkg::UV_HI_MAX)
						: clamp16(16'(hwdata[9:0]), msbs_pkg::UV_LO_MIN, msbs_pkg::UV_LO_MAX));
				end
				msbs_pkg::A_PREX: begin
					next_st.cfg.preex_t = clamp16(hwdata[msbs_pkg::LO_LSB +: 16], 16'h0000,
						msbs_pkg::PREEX_T_MAX);
					next_st.cfg.preex_lvl = 8'(clamp16(16'(hwdata[msbs_pkg::HI_LSB +: 8]),
						msbs_pkg::PREEX_LVL_MIN, msbs_pkg::PREEX_LVL_MAX));
				end
				msbs_pkg::A_STATUS: begin
					if (hwdata[msbs_pkg::ST_UV]) begin
						next_st.uv = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		if (!st.run2) begin
			next_st.need_rel = 1'b0;
		end
		next_st.ss_req = 1'b0;

		unique case (st.fsm)
			msbs_pkg::S_IDLE: begin
				if (st.run2 && !st.need_rel && !uv_low) begin
					next_st.ss_req = st.ss_pend;
					next_st.ss_pend = 1'b0;
					if (st.cfg.preex_t != 16'h0000) begin
						next_st.fsm = msbs_pkg::S_PREEX;
						next_st.timer = st.cfg.preex_t;
					end else begin
						step = brake_seq(pm, st.cfg.sc_start_t, st.cfg.dc_start_t,
							msbs_pkg::S_SSTART, msbs_pkg::S_DSTART, msbs_pkg::S_RUN);
						next_st.fsm = step.fsm;
						next_st.timer = step.timer;
					end
				end
			end
			msbs_pkg::S_PREEX, msbs_pkg::S_SSTART, msbs_pkg::S_DSTART: begin
				if (!st.run2) begin
					next_st.fsm = msbs_pkg::S_BLOCK;
					next_st.after = msbs_pkg::STOP_COAST;
					next_st.timer = st.cfg.bb_t;
				end else if (st.timer == 16'h0000) begin
					step = brake_seq(pm && st.fsm == msbs_pkg::S_PREEX, st.cfg.sc_start_t,
						(st.fsm == msbs_pkg::S_DSTART) ? 16'h0000 : st.cfg.dc_start_t,
						msbs_pkg::S_SSTART, msbs_pkg::S_DSTART, msbs_pkg::S_RUN);
					next_st.fsm = step.fsm;
					next_st.timer = step.timer;
				end
			end
			msbs_pkg::S_RUN: begin
				if (!st.run2) begin
					next_st.f_stop = out_freq;
					next_st.after = mode_eff;
					if (mode_eff == msbs_pkg::STOP_RAMP) begin
						next_st.fsm = msbs_pkg::S_DECEL;
					end else begin
						next_st.fsm = msbs_pkg::S_BLOCK;
						next_st.timer = st.cfg.bb_t;
						next_st.ss_pend = (mode_eff == msbs_pkg::STOP_COAST) && sensorless_vector_mode;
					end
				end
			end
			msbs_pkg::S_DECEL: begin
				if (st.run2) begin
					next_st.fsm = msbs_pkg::S_RUN;
				end else if (thr_hit) begin
					step = brake_seq(pm, st.cfg.sc_stop_t, st.cfg.dc_stop_t, msbs_pkg::S_SSTOP,
						msbs_pkg::S_DSTOP, msbs_pkg::S_IDLE);
					next_st.fsm = step.fsm;
					next_st.timer = step.timer;
				end
			end
			msbs_pkg::S_SSTOP: begin
				if (st.timer == 16'h0000) begin
					step = brake_seq(1'b0, 16'h0000, st.cfg.dc_stop_t, msbs_pkg::S_SSTOP,
						msbs_pkg::S_DSTOP, msbs_pkg::S_IDLE);
					next_st.fsm = step.fsm;
					next_st.timer = step.timer;
				end
			end
			msbs_pkg::S_BLOCK: begin
				// run commands are not looked at until the interval is over
				if (st.timer == 16'h0000) begin
					next_st.fsm = msbs_pkg::S_IDLE;
					if (st.after == msbs_pkg::STOP_DCB) begin
						step.timer = scale(st.cfg.dc_stop_t, 32'(msbs_pkg::DCDB_SCALE), st.f_stop,
							st.cfg.max_freq);
						step.fsm = msbs_pkg::S_BBDC;
					end else if (st.after == msbs_pkg::STOP_TIMER) begin
						step.timer = scale(st.cfg.decel_t, 32'h0000_0001, st.f_stop,
							st.cfg.max_freq);
						step.fsm = msbs_pkg::S_CTMR;
					end
					if (step.timer != 16'h0000) begin
						next_st.fsm = step.fsm;
						next_st.timer = step.timer;
					end
				end
			end
			msbs_pkg::S_DSTOP, msbs_pkg::S_BBDC, msbs_pkg::S_CTMR: begin
				if (st.timer == 16'h0000) begin
					next_st.fsm = msbs_pkg::S_IDLE;
				end
			end
			default: begin
				next_st.fsm = msbs_pkg::S_IDLE;
			end
		endcase

		// undervoltage overrides any sequence except a running block interval; run must be released before a new start
		if (uv_trip) begin
			next_st.uv = 1'b1;
			next_st.need_rel = 1'b1;
			if (st.fsm != msbs_pkg::S_IDLE && st.fsm != msbs_pkg::S_BLOCK) begin
				next_st.fsm = msbs_pkg::S_BLOCK;
				next_st.after = msbs_pkg::STOP_COAST;
				next_st.timer = st.cfg.bb_t;
			end
		end

		di_dc = next_st.fsm == msbs_pkg::S_IDLE && st.cfg.di_dc_en && st.dc2;
		di_sc = next_st.fsm == msbs_pkg::S_IDLE && st.cfg.di_sc_en && pm && st.sc2;
		next_st.blk = (next_st.fsm inside {msbs_pkg::S_IDLE, msbs_pkg::S_BLOCK,
			msbs_pkg::S_CTMR}) && !di_dc && !di_sc;
		next_st.dc_req = (next_st.fsm inside {msbs_pkg::S_DSTART, msbs_pkg::S_DSTOP,
			msbs_pkg::S_BBDC}) || di_dc;
		next_st.sc_req = (next_st.fsm inside {msbs_pkg::S_SSTART, msbs_pkg::S_SSTOP}) || di_sc;
		next_st.preex_req = next_st.fsm == msbs_pkg::S_PREEX;
		next_st.decel_req = next_st.fsm == msbs_pkg::S_DECEL;
		next_st.start_min = next_st.fsm == msbs_pkg::S_RUN && (st.cfg.dc_start_t == 16'h0000
			|| (pm && st.cfg.sc_stop_t == 16'h0000));
		cur_base = st.cfg.ain_en ? 8'(clamp16(16'(ain_level), 16'h0000, msbs_pkg::DC_CUR_MAX))
			: st.cfg.dc_cur;
		next_st.brk_cur = (cur_base > st.cfg.motor_pct) ? st.cfg.motor_pct : cur_base;

		// zero-wait slave; reads see the write of the cycle before
		next_st.hready = 1'b1;
		next_st.wr_pend = addr_ph && hwrite && hsize == msbs_pkg::HSIZE_WORD;
		next_st.wr_addr = haddr[7:0];
		if (addr_ph && !hwrite) begin
			next_st.hrdata = rd_mux(next_st, haddr[7:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '{cfg: msbs_pkg::CFG_RST, fsm: msbs_pkg::S_IDLE, after: msbs_pkg::STOP_RAMP,
				hready: 1'b1, blk: 1'b1, brk_cur: msbs_pkg::CFG_RST.dc_cur, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign hrdata = st.hrdata;
	assign hreadyout = st.hready;
	assign hresp = st.hresp;
	assign output_block = st.blk;
	assign dc_brake_req = st.dc_req;
	assign sc_brake_req = st.sc_req;
	assign brake_current = st.brk_cur;
	assign sc_current = st.cfg.sc_cur;
	assign preexcite_req = st.preex_req;
	assign preexcite_level = st.cfg.preex_lvl;
	assign decel_req = st.decel_req;
	assign speed_search_req = st.ss_req;
	assign start_at_min = st.start_min;
	assign undervoltage_fault = st.uv;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence sc_stop_done;
		st.fsm == msbs_pkg::S_SSTOP && st.timer == 16'h0000 && !uv_trip;
	endsequence
	sequence dc_follows;
		st.fsm == msbs_pkg::S_DSTOP && st.dc_req && !st.sc_req;
	endsequence

	chk_uv_immediate: assert property (uv_low && st.cfg.uv_t == 16'h0000 |=> st.uv [*2])
		else $error("undervoltage not flagged at once");
	chk_block_hold: assert property (st.fsm == msbs_pkg::S_BLOCK && st.timer != 16'h0000
		|=> st.fsm == msbs_pkg::S_BLOCK && st.blk)
		else $error("block interval left early");
	chk_pm_ramp_only: assert property (st.fsm == msbs_pkg::S_RUN && pm && !st.run2 && !uv_trip
		|=> st.fsm == msbs_pkg::S_DECEL && st.decel_req)
		else $error("pm motor took a non-ramp stop");
	chk_dc_clamp: assert property (##1 1 |-> st.brk_cur <= $past(st.cfg.motor_pct))
		else $error("dc current above motor rating");
	chk_sc_pm_only: assert property (st.sc_req |-> $past(pm))
		else $error("short-circuit braking outside pm mode");
	chk_stop_skip: assert property (st.fsm == msbs_pkg::S_DECEL && thr_hit && !st.run2 && !pm
		&& st.cfg.dc_stop_t == 16'h0000 && !uv_trip |=> st.fsm == msbs_pkg::S_IDLE)
		else $error("zero stop time still braked");
	chk_thr_fmin: assert property (st.fsm == msbs_pkg::S_DECEL && !st.run2 && !pm && !uv_trip
		&& st.cfg.brake_freq < st.cfg.min_freq && out_freq == st.cfg.min_freq
		&& st.cfg.dc_stop_t != 16'h0000 |=> st.fsm == msbs_pkg::S_DSTOP)
		else $error("braking not begun at minimum frequency");
	chk_pm_stop_seq: assert property (sc_stop_done ##0 (st.cfg.dc_stop_t != 16'h0000)
		|=> dc_follows)
		else $error("dc braking did not follow short-circuit braking");
	chk_preex_start: assert property (st.fsm == msbs_pkg::S_IDLE && st.run2 && !st.need_rel
		&& !uv_low && !uv_trip && st.cfg.preex_t != 16'h0000
		|=> st.preex_req && st.timer == $past(st.cfg.preex_t))
		else $error("run did not start pre-excitation");
	chk_dcdb_len: assert property ($rose(st.fsm == msbs_pkg::S_BBDC) |-> st.timer
		== scale(st.cfg.dc_stop_t, 32'(msbs_pkg::DCDB_SCALE), st.f_stop, st.cfg.max_freq))
		else $error("dc stop braking time wrong");
	chk_tick_gap: assert property (st.tick |=> !st.tick [*2])
		else $error("tick came too soon");
endmodule

// ### tb/msbs_stage_model.sv
// behavioural power stage: output frequency seen by the sequencer
`timescale 1ns/10ps
module msbs_stage_model #(
	parameter logic [15:0] RUNF = 16'h1000
) (
	input  wire logic        hclk,         // system clock
	input  wire logic        hresetn,      // async reset, active low
	input  wire logic        output_block, // outputs off
	input  wire logic        dc_brake_req, // dc injection active
	input  wire logic        decel_req,    // ramp down request
	output logic      [15:0] out_freq      // output frequency, 0.01 Hz
);
	// blocked outputs keep the last estimate, like a coasting rotor
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			out_freq <= 16'h0000;
		else if (decel_req)
			out_freq <= (out_freq > 16'h0100) ? out_freq - 16'h0100 : 16'h0000;
		else if (!output_block && !dc_brake_req)
			out_freq <= RUNF;
	end
endmodule

// ### tb/motor_stop_brake_sequencer_tb.sv
// testbench: register access, ramp stop with dc braking, coast stop, undervoltage
`timescale 1ns/10ps
module motor_stop_brake_sequencer_tb;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, run_pin = 0, dc_pin = 0;
	logic [7:0]  ain = 8'h00;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0]  htrans = '0;
	logic [9:0]  bus_volts = 10'h12C;
	logic        hreadyout, hresp, ob, dcr, scr, pxr, dr, ssr, sam, uvf;
	logic [7:0]  bc, pl;
	logic [11:0] scc;
	logic [15:0] freq;
	int          fail_count = 0, tests_run = 0, i;
	always #12.5 hclk = ~hclk;
	msbs_top #(.TICK_CYCLES(4)) i_msbs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(msbs_pkg::HSIZE_WORD),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .run_pin(run_pin), .dc_brake_pin(dc_pin), .sc_brake_pin(1'b0),
		.out_freq(freq), .bus_volts(bus_volts), .ain_level(ain), .output_block(ob),
		.dc_brake_req(dcr), .sc_brake_req(scr), .brake_current(bc), .sc_current(scc),
		.preexcite_req(pxr), .preexcite_level(pl), .decel_req(dr),
		.speed_search_req(ssr), .start_at_min(sam), .undervoltage_fault(uvf));
	msbs_stage_model i_msbs_stage_model (.hclk(hclk), .hresetn(hresetn),
		.output_block(ob), .dc_brake_req(dcr), .decel_req(dr), .out_freq(freq));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	// one single word transfer; each phase held until hready is seen high at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge hclk);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize;
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 8'h0C, 32'h0); chk(rd, 32'h03E8_6432);
		bus(1'b0, 8'h40, 32'h0); chk(rd, 32'h0000_0000);
		bus(1'b1, 8'h0C, 32'h0FFF_50FF);
		bus(1'b0, 8'h0C, 32'h0); chk(rd, 32'h07D0_5064);
		@(negedge hclk); chk({24'h0, bc}, 32'h0000_0050);
		chk({20'h0, scc}, 32'h0000_07D0);
		chk({24'h0, pl}, 32'h0000_0064);
		$display("test registers done");
		@(posedge hclk);
		run_pin <= 1'b1;
		for (i = 0; i < 30 && sam !== 1'b1; i++) @(negedge hclk);
		chkb(sam, 1'b1);
		@(posedge hclk);
		run_pin <= 1'b0;
		for (i = 0; i < 30 && dr !== 1'b1; i++) @(negedge hclk);
		chkb(dr, 1'b1);
		for (i = 0; i < 60 && dcr !== 1'b1; i++) @(negedge hclk);
		chkb(dcr, 1'b1);
		chkb(scr, 1'b0);
		chkb(freq < 16'h0096, 1'b1);
		for (i = 0; i < 400 && dcr === 1'b1; i++) @(negedge hclk);
		chkb(i >= 190 && i <= 205, 1'b1);
		$display("test ramp stop done");
		bus(1'b1, 8'h00, 32'h0000_0500);
		ain <= 8'h30;
		dc_pin <= 1'b1;
		repeat (5) @(negedge hclk);
		chkb(dcr, 1'b1);
		chk({24'h0, bc}, 32'h0000_0030);
		@(posedge hclk);
		dc_pin <= 1'b0;
		$display("test braking inputs done");
		bus(1'b1, 8'h00, 32'h0000_0012);
		run_pin <= 1'b1;
		repeat (20) @(posedge hclk);
		run_pin <= 1'b0;
		repeat (6) @(negedge hclk);
		chkb(ob, 1'b1);
		@(posedge hclk);
		run_pin <= 1'b1;
		repeat (20) @(negedge hclk);
		chkb(ob, 1'b1);
		for (i = 0; i < 400 && ssr !== 1'b1; i++) @(negedge hclk);
		chkb(ssr, 1'b1);
		chkb(i >= 150, 1'b1);
		@(negedge hclk); chkb(ssr, 1'b0);
		$display("test coast stop done");
		@(posedge hclk);
		bus_volts <= 10'h064;
		repeat (10) @(negedge hclk);
		chkb(uvf, 1'b1);
		chkb(ob, 1'b1);
		@(posedge hclk);
		bus_volts <= 10'h12C;
		for (i = 0; i < 300 && ob === 1'b1; i++) @(negedge hclk);
		chkb(ob, 1'b1);
		$display("test undervoltage done");
		summarize;
	end
endmodule
